// >>> verilog/clkgen_regs.svh
// Purpose: Constants of the clock generator control block.
// Assumes: Reference clock at 125 MHz.
// Notes:   Field widths without a documented figure are fixed here.
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

`define OSC_COUNT_W        8
`define OSC_PRESCALE_LAST  3'h7
`define MAIN_COUNT_W       16
`define MEAS_FALL_W        5
`define MEAS_PERIODS       5'h10
`define PLL_DIV_W          8
`define PLL_MUL_W          11
`define PLL_SETTLE_W       6
`define START_CNT_W        28
`define REF_CLK_MHZ        125
`define SLOW_XTAL_START_MS 1200
`define SLOW_RC_START_US   200
`define SLOW_XTAL_START_CYC (`SLOW_XTAL_START_MS * 1000 * `REF_CLK_MHZ)
`define SLOW_RC_START_CYC  (`SLOW_RC_START_US * `REF_CLK_MHZ)

`endif

// >>> verilog/clkgen_pkg.sv
// Purpose: Types shared by the clock generator control block.
// Assumes: clkgen_regs.svh gives the configuration field widths.
// Notes:   One-hot measurement states.
`include "clkgen_regs.svh"

package clkgen_pkg;

  typedef struct packed {
    logic                      enable;
    logic                      bypass;
    logic [`OSC_COUNT_W-1:0]   count;
  } osc_cfg_t;

  typedef struct packed {
    logic [`PLL_DIV_W-1:0]     div;
    logic [`PLL_MUL_W-1:0]     mul;
    logic [`PLL_SETTLE_W-1:0]  settle;
  } pll_cfg_t;

  typedef struct packed {
    pll_cfg_t                  cfg;
    logic [`PLL_SETTLE_W-1:0]  cnt;
    logic                      locked;
  } pll_state_t;

  typedef enum logic [3:0] {
    MEAS_IDLE  = 4'h1,
    MEAS_ARM   = 4'h2,
    MEAS_COUNT = 4'h4,
    MEAS_DONE  = 4'h8
  } meas_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

endpackage

// >>> verilog/pin_edge_sync.sv
// Purpose: Three-stage synchroniser with edge pulses for a pin input.
// Assumes: Input toggles well below half the reference clock rate.
// Notes:   Edges are taken from stages two and three only.
`timescale 1ns/1ps

module pin_edge_sync
  import clkgen_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.s3;
  assign rise  = st_ff.s2 & ~st_ff.s3;
  assign fall  = ~st_ff.s2 & st_ff.s3;

endmodule

// >>> verilog/clock_generator_osc_pll_control.sv
// Purpose: Control of main oscillator, frequency meter, slow start-up and two PLLs.
// Assumes: Slow and main clocks arrive as pins far slower than ref_clk.
// Notes:   Analogue parts are steered through the enable and setting outputs.
`timescale 1ns/1ps

`include "clkgen_regs.svh"

// Function
// - After reset the main oscillator is off and the slow clock runs.
// - Clearing the oscillator enable clears the stable flag.
// - Enable write clears stable and loads countdown clocked at slow clock / 8.
// - The start-up count field is 8 bits wide.
// - Countdown at zero sets stable flag; masked flag raises interrupt.
// - Once stable, count main clock cycles from the next slow rising edge.
// - On the 16th slow falling edge stop counting and set done.
// - Measured count is readable: main cycles from a slow rise to the 16th slow fall.
// - Each PLL input divider accepts 1 to 255.
// - Divider field 0 holds divider and PLL output at 0.
// - Reset clears every divider field to 0.
// - PLL output is source times (multiplier + 1) over divider.
// - Multiplier 0 powers down the PLL; nonzero re-enables it when the divider field is nonzero.
// - Re-enable or rewrite clears lock and loads the settle count.
// - PLL countdown steps each slow cycle; at zero lock sets, may interrupt.
// - Slow start-up delay is 1200 ms for crystal, 200 us for RC.
// - The slow clock runs permanently; other clocks may stop.
module clock_generator_osc_pll_control
  import clkgen_pkg::*;
#(
  parameter int unsigned XTAL_START_CYC = `SLOW_XTAL_START_CYC,
  parameter int unsigned RC_START_CYC   = `SLOW_RC_START_CYC
)
(
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  input  wire logic                      slow_clock,
  input  wire logic                      main_osc_clock,
  input  wire logic                      slow_source_select,
  input  wire logic                      osc_cfg_wr,
  input  wire osc_cfg_t                  osc_cfg_in,
  input  wire logic [1:0]                pll_cfg_wr,
  input  wire pll_cfg_t [1:0]            pll_cfg_in,
  input  wire logic [2:0]                irq_mask,
  output logic                           main_osc_enable,
  output logic                           osc_bypass_select,
  output logic [`OSC_COUNT_W-1:0]        osc_startup_count,
  output logic                           main_osc_power,
  output logic                           main_osc_stable,
  output logic                           freq_measure_done,
  output logic [`MAIN_COUNT_W-1:0]       main_cycle_count,
  output pll_cfg_t [1:0]                 pll_setting,
  output logic [1:0]                     pll_power,
  output logic [1:0]                     pll_div_run,
  output logic                           pll_a_locked,
  output logic                           pll_b_locked,
  output logic                           slow_source_xtal,
  output logic                           slow_clock_ready,
  output logic                           power_irq
);

  typedef struct packed {
    osc_cfg_t                  osc;
    logic [`OSC_COUNT_W-1:0]   osc_cnt;
    logic [2:0]                osc_pre;
    logic                      osc_run;
    logic                      stable;
    meas_state_t               meas;
    logic [`MEAS_FALL_W-1:0]   falls;
    logic [`MAIN_COUNT_W-1:0]  main_cnt;
    pll_state_t [1:0]          pll;
    logic                      src_taken;
    logic [1:0]                src_wait;
    logic                      src_xtal;
    logic [`START_CNT_W-1:0]   start_cnt;
    logic                      slow_ready;
    logic                      irq;
  } ctrl_state_t;

  ctrl_state_t st_ff;
  ctrl_state_t nxt_st;

  // Limits cut to the counter width once; the crystal figure needs all 28 bits
  localparam logic [`START_CNT_W-1:0] XTAL_LIMIT = `START_CNT_W'(XTAL_START_CYC);
  localparam logic [`START_CNT_W-1:0] RC_LIMIT   = `START_CNT_W'(RC_START_CYC);

  logic       slow_lvl;
  logic       slow_rise;
  logic       slow_fall;
  logic       main_rise;
  logic       src_lvl;
  logic       osc_tick;
  logic [2:0] status_bits;

  // Pins pass three flops; edges come from the second and third, so they are seen two cycles late
  pin_edge_sync u_slow_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin_in  (slow_clock),
    .level   (slow_lvl),
    .rise    (slow_rise),
    .fall    (slow_fall)
  );

  pin_edge_sync u_main_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin_in  (main_osc_clock),
    .level   (),
    .rise    (main_rise),
    .fall    ()
  );

  pin_edge_sync u_src_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin_in  (slow_source_select),
    .level   (src_lvl),
    .rise    (),
    .fall    ()
  );

  // Countdown end test shared by both counters; a count of 0 acts as 1
  function automatic logic count_ends(input logic [`OSC_COUNT_W-1:0] cnt);
    return (cnt <= `OSC_COUNT_W'(1));
  endfunction

  // One PLL channel: write handling, power-down and lock countdown
  function automatic pll_state_t pll_next(input pll_state_t cur,
                                          input logic       wr,
                                          input pll_cfg_t   cfg,
                                          input logic       tick);
    pll_state_t n;
    n = cur;
    if (wr) begin
      // A write beats a same-cycle lock: new settings need a fresh wait
      // clear lock, reload
      n.cfg    = cfg;
      n.cnt    = cfg.settle;
      n.locked = 1'b0;
    end else if (cur.cfg.mul == '0) begin
      n.locked = 1'b0;
    end else if (tick && !cur.locked) begin
      if (count_ends(`OSC_COUNT_W'(cur.cnt))) begin
        n.cnt    = '0;
        n.locked = 1'b1;
      end else begin
        n.cnt = cur.cnt - `PLL_SETTLE_W'(1);
      end
    end
    return n;
  endfunction

  // one-cycle tick at every eighth slow rise
  assign osc_tick    = slow_rise && (st_ff.osc_pre == `OSC_PRESCALE_LAST);
  // Status bits in interrupt mask order: {lock b, lock a, stable}
  assign status_bits = {st_ff.pll[1].locked, st_ff.pll[0].locked, st_ff.stable};

  always_comb begin
    nxt_st = st_ff;

    // Main oscillator control word
    // A write beats a same-cycle countdown end: the new count restarts the wait
    if (osc_cfg_wr) begin
      nxt_st.osc = osc_cfg_in;
      if (osc_cfg_in.enable) begin
        nxt_st.stable  = 1'b0;
        nxt_st.osc_cnt = osc_cfg_in.count;
        nxt_st.osc_pre = '0;
        nxt_st.osc_run = 1'b1;
      end else begin
        nxt_st.stable  = 1'b0;
        nxt_st.osc_run = 1'b0;
      end
    end else if (st_ff.osc_run && slow_rise) begin
      nxt_st.osc_pre = st_ff.osc_pre + 3'h1;
      if (osc_tick) begin
        if (count_ends(st_ff.osc_cnt)) begin
          nxt_st.osc_cnt = '0;
          nxt_st.osc_run = 1'b0;
          nxt_st.stable  = 1'b1;
        end else begin
          nxt_st.osc_cnt = st_ff.osc_cnt - `OSC_COUNT_W'(1);
        end
      end
    end

    // Frequency measurement; a lost stable flag restarts it
    if (!st_ff.stable) begin
      nxt_st.meas  = MEAS_IDLE;
    end else begin
      unique case (st_ff.meas)
        MEAS_IDLE: begin
          nxt_st.meas     = MEAS_ARM;
          nxt_st.main_cnt = '0;
          nxt_st.falls    = '0;
        end
        MEAS_ARM: begin
          if (slow_rise) begin
            nxt_st.meas = MEAS_COUNT;
          end
        end
        MEAS_COUNT: begin
          // A main edge in the stopping cycle still counts
          if (main_rise) begin
            nxt_st.main_cnt = st_ff.main_cnt + `MAIN_COUNT_W'(1);
          end
          if (slow_fall) begin
            nxt_st.falls = st_ff.falls + `MEAS_FALL_W'(1);
            if (st_ff.falls + `MEAS_FALL_W'(1) == `MEAS_PERIODS) begin
              nxt_st.meas = MEAS_DONE;
            end
          end
        end
        MEAS_DONE: begin
          nxt_st.meas = MEAS_DONE;
        end
        default: begin
          nxt_st.meas = MEAS_IDLE;
        end
      endcase
    end

    for (int i = 0; i < 2; i++) begin
      nxt_st.pll[i] = pll_next(st_ff.pll[i], pll_cfg_wr[i], pll_cfg_in[i], slow_rise);
    end

    // Strap taken once after reset, when the synchroniser has filled;
    // sooner it would still show the flops' reset zeros
    if (!st_ff.src_taken) begin
      if (st_ff.src_wait == 2'h3) begin
        nxt_st.src_taken = 1'b1;
        nxt_st.src_xtal  = src_lvl;
        nxt_st.start_cnt = '0;
      end else begin
        nxt_st.src_wait = st_ff.src_wait + 2'h1;
      end
    end else if (!st_ff.slow_ready) begin
      if (st_ff.start_cnt >= (st_ff.src_xtal ? XTAL_LIMIT : RC_LIMIT)) begin
        nxt_st.slow_ready = 1'b1;
      end else begin
        nxt_st.start_cnt = st_ff.start_cnt + `START_CNT_W'(1);
      end
    end

    // masked status drives the interrupt
    // Registered, so a flag that clears and sets in one cycle cannot glitch it
    nxt_st.irq = |(status_bits & irq_mask);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff      <= '0;
      st_ff.meas <= MEAS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign main_osc_enable   = st_ff.osc.enable;
  assign osc_bypass_select = st_ff.osc.bypass;
  assign osc_startup_count = st_ff.osc.count;
  // bypass keeps the crystal amplifier off
  assign main_osc_power    = st_ff.osc.enable & ~st_ff.osc.bypass;
  assign main_osc_stable   = st_ff.stable;
  assign freq_measure_done = (st_ff.meas == MEAS_DONE);
  assign main_cycle_count  = st_ff.main_cnt;
  assign pll_a_locked      = st_ff.pll[0].locked;
  assign pll_b_locked      = st_ff.pll[1].locked;
  assign slow_source_xtal  = st_ff.src_xtal;
  // slow clock is never gated here
  assign slow_clock_ready  = st_ff.slow_ready;
  assign power_irq         = st_ff.irq;

  // analogue PLL applies (mul + 1) / div
  for (genvar g = 0; g < 2; g++) begin : g_pll_out
    assign pll_setting[g] = st_ff.pll[g].cfg;
    // No divided input means nothing to multiply, so power stays off too
    // power follows multiplier and divider
    assign pll_power[g]   = (st_ff.pll[g].cfg.mul != '0) && (st_ff.pll[g].cfg.div != '0);
    assign pll_div_run[g] = (st_ff.pll[g].cfg.div != '0);
  end

endmodule

// >>> bench/clkgen_asserts.sv
// Purpose: Port-level checks of the clock generator control block.
// Assumes: Slow clock period spans many reference cycles.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/1ps
`include "clkgen_regs.svh"
module clkgen_asserts
  import clkgen_pkg::*;
#(
  parameter int unsigned XTAL_START_CYC = 20,
  parameter int unsigned RC_START_CYC   = 10
)
(
  input wire logic           ref_clk,
  input wire logic           resetn,
  input wire logic           osc_cfg_wr,
  input wire logic [1:0]     pll_cfg_wr,
  input wire pll_cfg_t [1:0] pll_cfg_in,
  input wire logic [2:0]     irq_mask,
  input wire logic           main_osc_enable,
  input wire logic           osc_bypass_select,
  input wire logic           main_osc_power,
  input wire logic           main_osc_stable,
  input wire logic           freq_measure_done,
  input wire pll_cfg_t [1:0] pll_setting,
  input wire logic [1:0]     pll_power,
  input wire logic [1:0]     pll_div_run,
  input wire logic           pll_a_locked,
  input wire logic           pll_b_locked,
  input wire logic           power_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // A settle of 1 may legally lock at the first slow rise, one cycle on
  sequence s_pll_a_wr;
    pll_cfg_wr[0] && pll_cfg_in[0].mul != 11'h000 && pll_cfg_in[0].settle > 6'h01;
  endsequence
  property p_osc_wr_clear; osc_cfg_wr |=> !main_osc_stable; endproperty
  property p_off_clear; !main_osc_enable |-> !main_osc_stable; endproperty
  property p_irq; $rose(main_osc_stable) && irq_mask[0] |=> power_irq; endproperty
  property p_done_drop; freq_measure_done && !main_osc_stable |=> !freq_measure_done; endproperty
  property p_lock_a_clear; s_pll_a_wr |=> !pll_a_locked [*2]; endproperty
  property p_lock_b_clear; pll_cfg_wr[1] |=> !pll_b_locked; endproperty
  property p_mul_zero; pll_setting[0].mul == 11'h000 |-> !pll_a_locked && !pll_power[0]; endproperty
  property p_div_zero;
    pll_cfg_wr[1] && pll_cfg_in[1].div == 8'h00 |=> !pll_div_run[1] && !pll_power[1];
  endproperty
  property p_bypass; osc_bypass_select |-> !main_osc_power; endproperty
  a_osc_wr_clear: assert property (p_osc_wr_clear)
    else $error("stable kept after oscillator write");
  a_off_clear: assert property (p_off_clear)
    else $error("stable set while oscillator disabled");
  a_irq: assert property (p_irq)
    else $error("no interrupt after stable");
  a_done_drop: assert property (p_done_drop)
    else $error("done kept after stable dropped");
  a_lock_a_clear: assert property (p_lock_a_clear)
    else $error("lock a kept after write");
  a_lock_b_clear: assert property (p_lock_b_clear)
    else $error("lock b kept after write");
  a_mul_zero: assert property (p_mul_zero)
    else $error("pll a active with zero multiplier");
  a_div_zero: assert property (p_div_zero)
    else $error("pll b divider runs with zero divider");
  a_bypass: assert property (p_bypass)
    else $error("oscillator powered in bypass");
endmodule

// >>> bench/clkgen_far_side.sv
// Purpose: Far side model: slow oscillator, main crystal, external clock.
// Assumes: Main clock only toggles while powered or bypassed.
// Notes:   Periods avoid coinciding with reference clock rising edges.
`timescale 1ns/1ps
module clkgen_far_side
(
  input  wire logic osc_on,
  input  wire logic ext_on,
  output logic      slow_clock,
  output logic      main_osc_clock
);
  initial slow_clock = 1'b0;
  initial main_osc_clock = 1'b0;
  always #40 slow_clock = ~slow_clock;
  always #20 main_osc_clock <= #1 ((osc_on | ext_on) ? ~main_osc_clock : 1'b0);
endmodule

// >>> bench/clock_generator_osc_pll_control_tb.sv
// Purpose: Directed test of oscillator, meter, PLL and slow start-up control.
// Assumes: Shortened slow start-up counts of 20 and 10 cycles.
// Notes:   Inputs change by NBA at rising edges, sampled 1 ns later.
`timescale 1ns/1ps
`include "clkgen_regs.svh"
bind clock_generator_osc_pll_control clkgen_asserts #(.XTAL_START_CYC(XTAL_START_CYC),
  .RC_START_CYC(RC_START_CYC)) u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .osc_cfg_wr(osc_cfg_wr), .pll_cfg_wr(pll_cfg_wr), .pll_cfg_in(pll_cfg_in),
  .irq_mask(irq_mask), .main_osc_enable(main_osc_enable), .osc_bypass_select(osc_bypass_select),
  .main_osc_power(main_osc_power), .main_osc_stable(main_osc_stable),
  .freq_measure_done(freq_measure_done), .pll_setting(pll_setting), .pll_power(pll_power),
  .pll_div_run(pll_div_run), .pll_a_locked(pll_a_locked), .pll_b_locked(pll_b_locked),
  .power_irq(power_irq));
module clock_generator_osc_pll_control_tb import clkgen_pkg::*;;
  logic           ref_clk, resetn, src_sel, osc_cfg_wr, slow_clock, main_osc_clock;
  osc_cfg_t       osc_cfg_in;
  pll_cfg_t [1:0] pll_cfg_in, pll_setting;
  logic [1:0]     pll_cfg_wr, pll_power, pll_div_run;
  logic [2:0]     irq_mask;
  logic [7:0]     osc_startup_count;
  logic [15:0]    main_cycle_count;
  logic           main_osc_enable, osc_bypass_select, main_osc_power, main_osc_stable;
  logic           freq_measure_done, pll_a_locked, pll_b_locked, slow_source_xtal;
  logic           slow_clock_ready, power_irq;
  logic [3:0]     flags;
  int             error_cnt, checked;
  assign flags = {pll_b_locked, pll_a_locked, freq_measure_done, main_osc_stable};
  clock_generator_osc_pll_control #(.XTAL_START_CYC(20), .RC_START_CYC(10)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .slow_clock(slow_clock),
    .main_osc_clock(main_osc_clock), .slow_source_select(src_sel), .osc_cfg_wr(osc_cfg_wr),
    .osc_cfg_in(osc_cfg_in), .pll_cfg_wr(pll_cfg_wr), .pll_cfg_in(pll_cfg_in),
    .irq_mask(irq_mask), .main_osc_enable(main_osc_enable),
    .osc_bypass_select(osc_bypass_select), .osc_startup_count(osc_startup_count),
    .main_osc_power(main_osc_power), .main_osc_stable(main_osc_stable),
    .freq_measure_done(freq_measure_done), .main_cycle_count(main_cycle_count),
    .pll_setting(pll_setting), .pll_power(pll_power), .pll_div_run(pll_div_run),
    .pll_a_locked(pll_a_locked), .pll_b_locked(pll_b_locked),
    .slow_source_xtal(slow_source_xtal), .slow_clock_ready(slow_clock_ready),
    .power_irq(power_irq));
  clkgen_far_side far (.osc_on(main_osc_power), .ext_on(osc_bypass_select),
    .slow_clock(slow_clock), .main_osc_clock(main_osc_clock));
  always #4 ref_clk = ~ref_clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic osc_write(input osc_cfg_t cfg);
    @(posedge ref_clk);
    osc_cfg_wr <= 1'b1;
    osc_cfg_in <= cfg;
    @(posedge ref_clk);
    osc_cfg_wr <= 1'b0;
    #1;
  endtask
  task automatic pll_write(input int i, input pll_cfg_t cfg);
    @(posedge ref_clk);
    pll_cfg_wr <= 2'h1 << i;
    pll_cfg_in[i] <= cfg;
    @(posedge ref_clk);
    pll_cfg_wr <= 2'h0;
    #1;
  endtask
  // Counts cycles until the chosen flag is high; a spent bound ends the run
  task automatic wait_flag(input int sel, input int lim, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > lim) begin
        error_cnt++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        finish_test();
      end
    end while (flags[sel] !== 1'b1);
  endtask
  initial begin
    int n;
    ref_clk = 1'b0;
    resetn = 1'b0;
    src_sel = 1'b1;
    osc_cfg_wr = 1'b0;
    osc_cfg_in = '0;
    pll_cfg_wr = 2'h0;
    pll_cfg_in = '0;
    irq_mask = 3'h7;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    check(main_osc_enable | main_osc_power, 1'b0);
    check(pll_div_run, 2'h0);
    check({pll_setting[1].div, pll_setting[0].div}, 16'h0000);
    check(slow_clock_ready, 1'b0);
    osc_write(10'h2FF);
    check(osc_startup_count, 8'hFF);
    check(main_osc_stable, 1'b0);
    osc_write(10'h203);
    wait_flag(0, 400, n);
    check(n >= 220 && n <= 255, 1'b1);
    @(posedge ref_clk);
    #1;
    check(power_irq, 1'b1);
    check({slow_source_xtal, slow_clock_ready}, 2'h3);
    wait_flag(1, 400, n);
    check(main_cycle_count >= 16'h001F && main_cycle_count <= 16'h0021, 1'b1);
    osc_write(10'h100);
    check({main_osc_stable, main_osc_power, osc_bypass_select}, 3'h1);
    @(posedge ref_clk);
    #1;
    check(freq_measure_done, 1'b0);
    for (int i = 0; i < 2; i++) begin
      pll_write(i, {8'h01, 11'h00A, 6'h05});
      check({flags[i+2], pll_power[i]}, 2'h1);
      wait_flag(i + 2, 200, n);
      check(n >= 38 && n <= 62, 1'b1);
      pll_write(i, {8'hFF, 11'h000, 6'h05});
      check(pll_setting[i], {8'hFF, 11'h000, 6'h05});
      check({pll_div_run[i], pll_power[i]}, 2'h2);
      repeat (100) @(posedge ref_clk);
      #1;
      check(flags[i+2], 1'b0);
      pll_write(i, {8'h00, 11'h00A, 6'h01});
      check({pll_div_run[i], pll_power[i]}, 2'h0);
    end
    @(posedge ref_clk);
    src_sel <= 1'b0;
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    check({slow_source_xtal, slow_clock_ready}, 2'h0);
    repeat (10) @(posedge ref_clk);
    #1;
    check({slow_source_xtal, slow_clock_ready}, 2'h1);
    check({main_osc_enable, pll_div_run}, 3'h0);
    finish_test();
  end
endmodule
